// File: hw/cfgrd_consts.svh
// constants of the configuration memory read-out block
`ifndef CFGRD_CONSTS_SVH
`define CFGRD_CONSTS_SVH

// system clock period
`define CFGRD_CLK_NS       100
// configure pulse width bounds
`define CFGRD_PULSE_MIN_NS 300
`define CFGRD_PULSE_MAX_NS 500
// least cycles, rounded up
`define CFGRD_PULSE_MIN_CYC ((`CFGRD_PULSE_MIN_NS + `CFGRD_CLK_NS - 1) / `CFGRD_CLK_NS)
// most cycles, rounded down
`define CFGRD_PULSE_MAX_CYC (`CFGRD_PULSE_MAX_NS / `CFGRD_CLK_NS)
// cycles used: midway between bounds
`define CFGRD_PULSE_CYC ((`CFGRD_PULSE_MIN_CYC + `CFGRD_PULSE_MAX_CYC) / 2)
// revision field width
`define CFGRD_REV_W        2
// default address width per revision
`define CFGRD_ADDR_W       10
// default clock output divider (half period)
`define CFGRD_MEMORY_CLOCK_OUTPUT_DIV   2
// reset value of the revision
`define CFGRD_REV_RST      2'h0

`endif

// File: hw/cfgrd_pkg.sv
// types of the configuration memory read-out block
package cfgrd_pkg;

	// configure command sequencer, gray coded
	typedef enum logic [1:0] {
		CMD_IDLE   = 2'b00,
		CMD_SAMPLE = 2'b01,
		CMD_PULSE  = 2'b11,
		CMD_END    = 2'b10
	} cfgrd_cmd_t;

	// link side state carried together
	typedef struct packed {
		logic [15:0] addr;  // byte counter
		logic        done;  // last byte read
		logic [7:0]  data;  // byte on the pins
		logic        drive; // data pins driven
	} cfgrd_link_t;

	// program port carried together
	typedef struct packed {
		logic        we;
		logic [17:0] addr;
		logic [7:0]  data;
	} cfgrd_load_t;

endpackage

// File: hw/cfgrd_readout.sv
// configuration memory byte read-out with cascade and configure pulse
// Behaviour
// - one byte per clock edge, counter advances
// - busy high holds byte and counter
// - after completion, disable resets the counter
// - data driven while chip enable low
// - after last byte: chain low, data floats
// - chip enable low enables data on the third link clock edge
// - clock from own output or external
// - configure command pulses line low once
// - pulse line rising edge latches revision
// - configure command samples revision on the edge the pulse starts
// - disable: counter reset, chain high, floats
`timescale 1ns/10ps
`include "cfgrd_consts.svh"

module cfgrd_readout #(
	parameter int ADDR_W = `CFGRD_ADDR_W,     // bytes per revision, log2
	parameter int DIV    = `CFGRD_MEMORY_CLOCK_OUTPUT_DIV  // clock output half period
) (
	input  wire logic                    CLK,
	input  wire logic                    RESET,
	input  wire logic                    CONFIG_CLOCK,
	input  wire logic                    OE_RESET_N,
	input  wire logic                    CE_N,
	input  wire logic                    BUSY,
	input  wire logic                    JTAG_CONFIG,
	input  wire logic                    EXTERNAL_SELECT_ENABLE,
	input  wire logic [`CFGRD_REV_W-1:0] REVISION_SELECT_PINS,
	input  wire logic [`CFGRD_REV_W-1:0] INTERNAL_REVISION,
	input  wire logic                    CONFIG_PULSE_LINE_IN,
	input  wire cfgrd_pkg::cfgrd_load_t  LOAD,
	output logic                         CONFIG_PULSE_LINE_OUT,
	output logic                         CONFIG_PULSE_LINE_OE_N,
	output logic [7:0]                   DATA_OUT_BYTE,
	output logic                         DATA_OUT_OE_N,
	output logic                         CHAIN_ENABLE_OUT_N,
	output logic                         MEMORY_CLOCK_OUTPUT,
	output logic [`CFGRD_REV_W-1:0]      REVISION_ACTIVE
);

	localparam int REV_W = `CFGRD_REV_W;
	localparam int MEM_W = ADDR_W + REV_W;
	localparam logic [2:0] PULSE_CYC = 3'(`CFGRD_PULSE_CYC);

	// refuse sizes the carriers cannot hold
	if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_addr
		$error("ADDR_W must be 1 to 16");
	end
	if (DIV < 1 || DIV > 255) begin : g_bad_div
		$error("DIV must be 1 to 255");
	end

	// last byte index within a revision
	function automatic logic [15:0] last_addr();
		return 16'((1 << ADDR_W) - 1);
	endfunction

	// memory index from revision and counter
	function automatic logic [MEM_W-1:0] mem_index(
		input logic [REV_W-1:0] rev,
		input logic [15:0]      addr
	);
		return {rev, addr[ADDR_W-1:0]};
	endfunction

	// bitstream storage, all revisions
	logic [7:0] mem [0:(1<<MEM_W)-1];

	// program port writes, system clock
	always_ff @(posedge CLK) begin
		if (LOAD.we) begin
			mem[LOAD.addr[MEM_W-1:0]] <= LOAD.data;
		end
	end

	// ---- system clock domain ----

	// pin synchronisers
	logic [REV_W-1:0] rsel_s1, rsel_s2;   // revision pins
	logic             esel_s1, esel_s2;   // external select enable
	logic             cfl_s1, cfl_s2;     // pulse line level
	logic             cfl_d;              // previous pulse line level

	// two flops on each pin, then edge history
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			rsel_s1 <= '0;
			rsel_s2 <= '0;
			esel_s1 <= 1'b0;
			esel_s2 <= 1'b0;
			cfl_s1  <= 1'b1;
			cfl_s2  <= 1'b1;
			cfl_d   <= 1'b1;
		end else begin
			rsel_s1 <= REVISION_SELECT_PINS;
			rsel_s2 <= rsel_s1;
			esel_s1 <= EXTERNAL_SELECT_ENABLE;
			esel_s2 <= esel_s1;
			cfl_s1  <= CONFIG_PULSE_LINE_IN;
			cfl_s2  <= cfl_s1;
			cfl_d   <= cfl_s2;
		end
	end

	// configure sequencer and revision latch
	cfgrd_pkg::cfgrd_cmd_t state, next_state;
	logic [2:0]            cnt, next_cnt;        // pulse width counter
	logic [REV_W-1:0]      rev, next_rev;        // active revision
	logic                  rev_tgl, next_rev_tgl; // revision change event
	logic                  cfl_rise;             // line rising edge
	logic [REV_W-1:0]      rev_pick;             // revision source mux

	// next values of the sequencer
	always_comb begin
		next_state   = state;
		next_cnt     = cnt;
		next_rev     = rev;
		next_rev_tgl = rev_tgl;
		cfl_rise     = cfl_s2 && !cfl_d;
		// pins when external select, else internal bits
		rev_pick = esel_s2 ? rsel_s2 : INTERNAL_REVISION;
		case (state)
			cfgrd_pkg::CMD_IDLE: begin
				// command waits for the revision sample
				if (JTAG_CONFIG) begin
					next_state = cfgrd_pkg::CMD_SAMPLE;
				end
			end
			cfgrd_pkg::CMD_SAMPLE: begin
				// sample on the same edge the pulse starts
				next_rev     = rev_pick;
				next_rev_tgl = !rev_tgl;
				next_cnt     = PULSE_CYC;
				next_state   = cfgrd_pkg::CMD_PULSE;
			end
			cfgrd_pkg::CMD_PULSE: begin
				// hold the line low for the pulse width
				next_cnt = cnt - 3'h1;
				if (cnt == 3'h1) begin
					next_state = cfgrd_pkg::CMD_END;
				end
			end
			cfgrd_pkg::CMD_END: begin
				// line released; only one pulse per command
				if (!JTAG_CONFIG) begin
					next_state = cfgrd_pkg::CMD_IDLE;
				end
			end
			default: begin
				next_state = cfgrd_pkg::CMD_IDLE;
			end
		endcase
		// any rising edge of the line latches the revision
		if (cfl_rise) begin
			next_rev     = rev_pick;
			// one flip even when a command sample shares the edge
			next_rev_tgl = !rev_tgl;
		end
	end

	// sequencer registers
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			state   <= cfgrd_pkg::CMD_IDLE;
			cnt     <= 3'h0;
			rev     <= `CFGRD_REV_RST;
			rev_tgl <= 1'b0;
		end else begin
			state   <= next_state;
			cnt     <= next_cnt;
			rev     <= next_rev;
			rev_tgl <= next_rev_tgl;
		end
	end

	// pulse line: driven low only during the pulse, else released
	logic cfl_oe_n, next_cfl_oe_n;

	// output enable follows the pulse state
	always_comb begin
		next_cfl_oe_n = (next_state != cfgrd_pkg::CMD_PULSE);
	end

	// registered enable so the pin is glitch free
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			cfl_oe_n <= 1'b1;
		end else begin
			cfl_oe_n <= next_cfl_oe_n;
		end
	end

	assign CONFIG_PULSE_LINE_OUT  = 1'b0;
	assign CONFIG_PULSE_LINE_OE_N = cfl_oe_n;
	assign REVISION_ACTIVE        = rev;

	// own clock output for the fpga, divided from system clock
	logic [7:0] div_cnt, next_div_cnt; // half period counter
	logic       clk_out, next_clk_out; // divided clock level

	// divider next values
	always_comb begin
		next_div_cnt = div_cnt + 8'h1;
		next_clk_out = clk_out;
		if (div_cnt == 8'(DIV - 1)) begin
			next_div_cnt = 8'h0;
			next_clk_out = !clk_out;
		end
	end

	// divider registers
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			div_cnt <= 8'h0;
			clk_out <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			clk_out <= next_clk_out;
		end
	end

	assign MEMORY_CLOCK_OUTPUT = clk_out;

	// ---- link clock domain ----

	// reset release synchroniser for the link domain
	logic lrst_s1, lrst;

	// async assert, release on the link clock
	always_ff @(posedge CONFIG_CLOCK or posedge RESET) begin
		if (RESET) begin
			lrst_s1 <= 1'b1;
			lrst    <= 1'b1;
		end else begin
			lrst_s1 <= 1'b0;
			lrst    <= lrst_s1;
		end
	end

	// link pins and revision toggle through two flops
	logic oe_s1, oe_s2;     // output enable / reset pin
	logic ce_s1, ce_s2;     // chip enable pin
	logic bsy_s1, bsy_s2;   // busy pin
	logic tg_s1, tg_s2;     // revision toggle
	logic tg_d;             // toggle history

	// synchronisers on the link clock
	always_ff @(posedge CONFIG_CLOCK or posedge lrst) begin
		if (lrst) begin
			oe_s1  <= 1'b0;
			oe_s2  <= 1'b0;
			ce_s1  <= 1'b1;
			ce_s2  <= 1'b1;
			bsy_s1 <= 1'b0;
			bsy_s2 <= 1'b0;
			tg_s1  <= 1'b0;
			tg_s2  <= 1'b0;
			tg_d   <= 1'b0;
		end else begin
			oe_s1  <= OE_RESET_N;
			oe_s2  <= oe_s1;
			ce_s1  <= CE_N;
			ce_s2  <= ce_s1;
			bsy_s1 <= BUSY;
			bsy_s2 <= bsy_s1;
			tg_s1  <= rev_tgl;
			tg_s2  <= tg_s1;
			tg_d   <= tg_s2;
		end
	end

	// read-out state
	cfgrd_pkg::cfgrd_link_t lk, next_lk;
	logic [REV_W-1:0]       lrev, next_lrev; // revision on link side
	logic                   off;             // outputs disabled

	// read-out next values
	always_comb begin
		next_lk   = lk;
		next_lrev = lrev;
		off       = !oe_s2 || ce_s2;
		// revision word is stable when its toggle is seen
		if (tg_s2 != tg_d) begin
			next_lrev = rev;
		end
		if (off) begin
			// disabled: counter home, no advance
			next_lk.addr  = 16'h0;
			next_lk.done  = 1'b0;
			next_lk.drive = 1'b0;
			next_lk.data  = mem[mem_index(next_lrev, 16'h0)];
		end else if (!lk.done) begin
			next_lk.drive = 1'b1;
			if (!lk.drive) begin
				// first enabled edge presents byte zero
				next_lk.data = mem[mem_index(lrev, lk.addr)];
			end else if (!bsy_s2) begin
				// ready: step to the next byte
				if (lk.addr == last_addr()) begin
					next_lk.done  = 1'b1;
					next_lk.drive = 1'b0;
				end else begin
					next_lk.addr = lk.addr + 16'h1;
					next_lk.data = mem[mem_index(lrev, next_lk.addr)];
				end
			end
			// busy high: byte and counter held
		end
	end

	// read-out registers
	always_ff @(posedge CONFIG_CLOCK or posedge lrst) begin
		if (lrst) begin
			lk   <= '0;
			lrev <= `CFGRD_REV_RST;
		end else begin
			lk   <= next_lk;
			lrev <= next_lrev;
		end
	end

	// pins: data from flops, chain low once done
	assign DATA_OUT_BYTE      = lk.data;
	assign DATA_OUT_OE_N      = !lk.drive;
	assign CHAIN_ENABLE_OUT_N = !lk.done;

endmodule

// File: dv/cfgrd_monitor.sv
// port checker of the configuration read-out block
`timescale 1ns/10ps
module cfgrd_monitor #(
	parameter int ADDR_W = 10, // bytes per revision, log2
	parameter int DIV    = 2   // clock output half period
) (
	input wire logic       CLK,
	input wire logic       RESET,
	input wire logic       CONFIG_CLOCK,
	input wire logic       OE_RESET_N,
	input wire logic       CE_N,
	input wire logic       BUSY,
	input wire logic       JTAG_CONFIG,
	input wire logic       EXTERNAL_SELECT_ENABLE,
	input wire logic [1:0] REVISION_SELECT_PINS,
	input wire logic [1:0] INTERNAL_REVISION,
	input wire logic       CONFIG_PULSE_LINE_OUT,
	input wire logic       CONFIG_PULSE_LINE_OE_N,
	input wire logic [7:0] DATA_OUT_BYTE,
	input wire logic       DATA_OUT_OE_N,
	input wire logic       CHAIN_ENABLE_OUT_N,
	input wire logic       MEMORY_CLOCK_OUTPUT,
	input wire logic [1:0] REVISION_ACTIVE
);
	// command in idle starts the low pulse two edges on
	cmd_start_a: assert property (@(posedge CLK) disable iff (RESET)
		$rose(JTAG_CONFIG) && CONFIG_PULSE_LINE_OE_N |-> ##2 $fell(CONFIG_PULSE_LINE_OE_N))
		else $error("configure pulse late");
	// pulse low exactly four cycles, line driven low
	pulse_width_a: assert property (@(posedge CLK) disable iff (RESET)
		$fell(CONFIG_PULSE_LINE_OE_N) |-> (!CONFIG_PULSE_LINE_OE_N && !CONFIG_PULSE_LINE_OUT)[*4]
		##1 CONFIG_PULSE_LINE_OE_N) else $error("configure pulse width wrong");
	// revision sampled by the edge the pulse starts
	rev_sample_a: assert property (@(posedge CLK) disable iff (RESET)
		$rose(JTAG_CONFIG) && CONFIG_PULSE_LINE_OE_N |-> ##2 REVISION_ACTIVE ==
		(EXTERNAL_SELECT_ENABLE ? REVISION_SELECT_PINS : INTERNAL_REVISION))
		else $error("revision not sampled");
	// clock output high for two cycles per half period
	clock_out_a: assert property (@(posedge CLK) disable iff (RESET)
		$rose(MEMORY_CLOCK_OUTPUT) |=> MEMORY_CLOCK_OUTPUT ##1 !MEMORY_CLOCK_OUTPUT)
		else $error("clock output period wrong");
	// enable drives the data pins promptly
	enable_drive_a: assert property (@(posedge CONFIG_CLOCK) disable iff (RESET)
		$rose(OE_RESET_N) && !CE_N |-> ##[3:4] !DATA_OUT_OE_N)
		else $error("data not driven after enable");
	// busy held high freezes the byte
	busy_hold_a: assert property (@(posedge CONFIG_CLOCK) disable iff (RESET)
		BUSY[*4] ##1 (!DATA_OUT_OE_N && !$past(DATA_OUT_OE_N)) |-> $stable(DATA_OUT_BYTE))
		else $error("byte moved while busy");
	// disable floats data and raises chain output
	float_off_a: assert property (@(posedge CONFIG_CLOCK) disable iff (RESET)
		(!OE_RESET_N || CE_N)[*5] |-> DATA_OUT_OE_N && CHAIN_ENABLE_OUT_N)
		else $error("outputs not released on disable");
	// chain output low only with data floated
	chain_done_a: assert property (@(posedge CONFIG_CLOCK) disable iff (RESET)
		$fell(CHAIN_ENABLE_OUT_N) |-> DATA_OUT_OE_N)
		else $error("chain low while data driven");
endmodule
bind cfgrd_readout cfgrd_monitor #(.ADDR_W(ADDR_W), .DIV(DIV)) u_cfgrd_monitor (.*);

// File: dv/cfgrd_fpga_model.sv
// behavioural fpga configuration port on the link side
`timescale 1ns/10ps
module cfgrd_fpga_model #(
	parameter int NBYTES = 8 // bytes per image
) (
	input  wire logic       link_clk,
	input  wire logic       init_n,
	input  wire logic       stall,
	input  wire logic [7:0] data_in,
	input  wire logic       data_oe_n,
	output logic            busy,
	output logic            done,
	output logic            fpga_write_n,
	output logic            fpga_select_n
);
	logic [7:0] rx [$];         // bytes taken in order
	logic [7:0] last  = 8'h00;  // byte seen before
	logic [2:0] phase = 3'h0;   // stall pattern step
	assign fpga_write_n  = 1'b0;
	assign fpga_select_n = 1'b0;
	// slow mode: five busy edges, three ready
	assign busy = stall && (phase < 3'h5);
	// take each new byte; done feeds chip enable
	always @(posedge link_clk) begin
		phase <= phase + 3'h1;
		if (!init_n) begin
			rx.delete();
			done <= 1'b0;
			last <= 8'h00;
		end else if (!data_oe_n && data_in !== last && !done) begin
			rx.push_back(data_in);
			last <= data_in;
			done <= (rx.size() == NBYTES);
		end
	end
endmodule

// File: dv/test_config_prom_parallel_readout.sv
// self-checking bench of the configuration read-out block
`timescale 1ns/10ps
module test_config_prom_parallel_readout;
	logic clk = 1'b0, link_clk = 1'b0, reset = 1'b1, oe_reset_n = 1'b0, jtag = 1'b0;
	logic ext_sel = 1'b0, ext_low = 1'b0, stall = 1'b0;
	logic [1:0] rev_pins = 2'h0, int_rev = 2'h0, rev_act;
	logic [7:0] data;
	logic       pulse_out, pulse_oe_n, data_oe_n, chain_n, mclk, ce_n, busy;
	cfgrd_pkg::cfgrd_load_t load = '0;
	int mismatches = 0;
	int cmp_count = 0;
	// pulled-up pulse line, low when driven
	wire pulse_in = !ext_low && (pulse_oe_n || pulse_out);
	cfgrd_readout #(.ADDR_W(3), .DIV(2)) u_cfgrd_readout (
		.CLK(clk), .RESET(reset), .CONFIG_CLOCK(link_clk), .OE_RESET_N(oe_reset_n),
		.CE_N(ce_n), .BUSY(busy), .JTAG_CONFIG(jtag), .EXTERNAL_SELECT_ENABLE(ext_sel),
		.REVISION_SELECT_PINS(rev_pins), .INTERNAL_REVISION(int_rev),
		.CONFIG_PULSE_LINE_IN(pulse_in), .LOAD(load), .CONFIG_PULSE_LINE_OUT(pulse_out),
		.CONFIG_PULSE_LINE_OE_N(pulse_oe_n), .DATA_OUT_BYTE(data), .DATA_OUT_OE_N(data_oe_n),
		.CHAIN_ENABLE_OUT_N(chain_n), .MEMORY_CLOCK_OUTPUT(mclk), .REVISION_ACTIVE(rev_act));
	// partner shares the link clock and data lines
	cfgrd_fpga_model u_cfgrd_fpga_model (.link_clk(link_clk), .init_n(oe_reset_n),
		.stall(stall), .data_in(data), .data_oe_n(data_oe_n), .busy(busy), .done(ce_n),
		.fpga_write_n(), .fpga_select_n());
	// clocks: 100 ns system, 125 ns link, phases unrelated
	initial forever #50 clk = ~clk;
	initial begin
		#17;
		forever #62.5 link_clk = ~link_clk;
	end
	// image byte of a revision
	function automatic logic [7:0] img(input logic [1:0] r, input int i);
		return 8'(r * 16 + i + 1);
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// fill four revisions of eight bytes
	task automatic load_all();
		for (int k = 0; k < 32; k++) begin
			@(posedge clk);
			load <= '{we: 1'b1, addr: 18'(k), data: img(2'(k / 8), k % 8)};
		end
		@(posedge clk);
		load.we <= 1'b0;
	endtask
	// configure command, own pulse end, then external re-latch
	task automatic t_config(input logic [1:0] r, input logic ext);
		@(posedge clk);
		ext_sel <= ext;
		rev_pins <= ext ? r : ~r;
		int_rev <= ext ? ~r : r;
		repeat (4) @(posedge clk);
		jtag <= 1'b1;
		@(posedge clk);
		jtag <= 1'b0;
		#1 check(8'(pulse_oe_n), 8'h01);
		@(posedge clk);
		#1 check(8'(rev_act), 8'(r));
		check(8'(pulse_oe_n), 8'h00);
		@(posedge clk);
		#1 check(8'(pulse_oe_n), 8'h00);
		repeat (2) @(posedge clk);
		#1 check(8'(pulse_oe_n), 8'h00);
		@(posedge clk);
		#1 check(8'(pulse_oe_n), 8'h01);
		repeat (5) @(posedge clk);
		#1 check(8'(rev_act), 8'(r));
		@(posedge clk);
		rev_pins <= r ^ 2'h2;
		int_rev <= r ^ 2'h2;
		repeat (3) @(posedge clk);
		ext_low <= 1'b1;
		repeat (3) @(posedge clk);
		ext_low <= 1'b0;
		repeat (8) @(posedge clk);
		#1 check(8'(rev_act), 8'(r ^ 2'h2));
		$display("config test rev %0d done", r);
	endtask
	// own clock output: half period of two system cycles
	task automatic t_clock_out();
		logic m0;
		@(posedge clk);
		#1 m0 = mclk;
		repeat (2) @(posedge clk);
		#1 check(8'(mclk), 8'(!m0));
		repeat (2) @(posedge clk);
		#1 check(8'(mclk), 8'(m0));
		$display("clock output test done");
	endtask
	// read cut short by output enable low
	task automatic t_abort();
		@(posedge clk);
		stall <= 1'b0;
		oe_reset_n <= 1'b1;
		repeat (8) @(posedge clk);
		#1 check(8'(data_oe_n), 8'h00);
		check(8'(chain_n), 8'h01);
		@(posedge clk);
		oe_reset_n <= 1'b0;
		repeat (8) @(posedge clk);
		#1 check(8'({data_oe_n, chain_n}), 8'h03);
		$display("abort test done");
	endtask
	// one whole image read, then disable
	task automatic t_stream(input logic slow, input logic [1:0] r);
		int n;
		logic chain_seen;
		n = 0;
		chain_seen = 1'b0;
		@(posedge clk);
		stall <= slow;
		oe_reset_n <= 1'b1;
		while (n < 600 && !(ce_n === 1'b1 && n > 40)) begin
			@(posedge clk);
			chain_seen |= (chain_n === 1'b0);
			n++;
		end
		check(8'(u_cfgrd_fpga_model.rx.size()), 8'h08);
		for (int i = 0; i < 8; i++)
			check(u_cfgrd_fpga_model.rx[i], img(r, i));
		check(8'(chain_seen), 8'h01);
		oe_reset_n <= 1'b0;
		repeat (8) @(posedge clk);
		#1 check(8'({data_oe_n, chain_n}), 8'h03);
		$display("stream test slow=%0d done", slow);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		load_all();
		for (int r = 0; r < 4; r++)
			t_config(2'(r), r[0]);
		t_clock_out();
		t_abort();
		t_stream(1'b0, 2'h1);
		t_stream(1'b1, 2'h1);
		tally_and_finish();
	end
	// hang guard
	initial begin
		#500000;
		mismatches++;
		tally_and_finish();
	end
endmodule
